// ==== rtl/sfrc_pkg.sv ====
// Package of constants and types for the special function register core
// Function
// - Unused special locations read as zero
// - Window access redirects to pointer address
// - Window 0 bank 0; window 1 selected bank
// - Pointer at a window: read zero, write ignored
// - Direct access always targets bank 0
// - Bank bit at bit 0, others zero
// - Reset clears bank except sleep watchdog reset
// - Counter low write: page jump, dummy cycle
// - Table read: high byte to table register
// - Status writes keep watchdog and sleep flags
// - Watchdog flag: cleared power-up/clear/sleep, set timeout
// - Sleep flag: cleared power-up/clear, set by sleep
// - Carry set by add carry, no borrow, rotate
// - Half flag from low nibble carry
// - Null flag set on zero result
// - Range flag: carry into and out differ
// - Status never saved on calls or interrupts
// - Status bits 7,6 zero; power-on flags zero
// - No direct register move; via result register
package sfrc_pkg;
  localparam logic [31:0] ADDR_BANK = 32'h0000_0000;
  localparam logic [31:0] ADDR_STATUS = 32'h0000_0004;
  localparam logic [31:0] ADDR_PTR0 = 32'h0000_0008;
  localparam logic [31:0] ADDR_PTR1 = 32'h0000_000C;
  localparam logic [31:0] ADDR_PC_LOW = 32'h0000_0010;
  localparam logic [31:0] ADDR_TBLP = 32'h0000_0014;
  localparam logic [31:0] ADDR_TABLE_HIGH = 32'h0000_0018;
  localparam logic [31:0] ADDR_RESULT = 32'h0000_001C;
  localparam logic [31:0] ADDR_CMD = 32'h0000_0020;
  localparam logic [31:0] ADDR_WIN0 = 32'h0000_0024;
  localparam logic [31:0] ADDR_WIN1 = 32'h0000_0028;
  localparam logic [31:0] ADDR_DIRECT = 32'h0000_002C;
  localparam logic [31:0] ADDR_PCH = 32'h0000_0030;
  localparam logic [31:0] ADDR_PCFULL = 32'h0000_0034;
  localparam logic [31:0] ADDR_EXPAND = 32'h0000_0038;
  localparam logic [31:0] ADDR_TBLDATA = 32'h0000_003C;
  localparam logic [7:0] ADDR_MEM_BASE = 8'h40;
  localparam int BANK_BIT = 0;
  localparam int ST_CARRY = 0;
  localparam int ST_HALF = 1;
  localparam int ST_NULL = 2;
  localparam int ST_RANGE = 3;
  localparam int ST_SLEEP = 4;
  localparam int ST_WDOG = 5;
  localparam logic [7:0] BANK_RESET = 8'h00;
  localparam logic [7:0] ZERO_BYTE = 8'h00;
  localparam logic [7:0] WIN0_LOC = 8'h00;
  localparam logic [7:0] WIN1_LOC = 8'h02;
  localparam logic [7:0] GP_BASE = 8'h80;
  localparam logic [7:0] MASK_STATUS_WR = 8'h0F;
  localparam logic [31:0] CMD_NONE = 32'h0000_0000;
  typedef enum logic [3:0] {
    SFRC_OP_ADD = 4'h1,
    SFRC_OP_SUB = 4'h2,
    SFRC_OP_AND = 4'h3,
    SFRC_OP_OR = 4'h4,
    SFRC_OP_XOR = 4'h5,
    SFRC_OP_RLC = 4'h6,
    SFRC_OP_RRC = 4'h7,
    SFRC_OP_WDOG_CLEAR = 4'h8,
    SFRC_OP_HALT = 4'h9,
    SFRC_OP_WDTO = 4'hA,
    SFRC_OP_TABRD = 4'hB,
    SFRC_OP_MOVA = 4'hC
  } sfrc_op_t;
  typedef struct packed {
    logic carry;
    logic [7:0] value;
    logic half;
    logic range;
  } sfrc_alu_t;
endpackage : sfrc_pkg

// ==== rtl/sfrc_core.sv ====
// Special function register core behind an APB slave
//
// The register addresses and the APB slave port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module sfrc_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic watchdog_reset,
  input wire logic [15:0] prog_word,
  output logic [10:0] prog_addr,
  output logic [10:0] pc,
  output logic dummy_cycle
);
  // Data memory; both banks have 256 entries, but only locations 0x80 and up are written or read
  logic [7:0] mem0 [0:255];
  logic [7:0] mem1 [0:255];
  logic [7:0] bank_select_register;
  logic [7:0] status_flags_register;
  logic [7:0] memory_pointer_0;
  logic [7:0] memory_pointer_1;
  logic [7:0] table_pointer;
  logic [7:0] table_high_byte;
  logic [7:0] result_holding_register;
  logic [10:0] pc_q;
  logic sleeping;
  logic access;
  logic wr_en;
  logic rd_en;
  logic [7:0] wbyte;
  logic tab_pend;
  logic [7:0] tab_dest;
  logic [7:0] next_rd;
  sfrc_pkg::sfrc_alu_t alu;

  assign access = psel && penable;
  assign wr_en = access && pwrite;
  assign rd_en = access && !pwrite;
  assign wbyte = pwdata[7:0];

  function automatic logic is_window(input logic [7:0] a);
    is_window = (a == sfrc_pkg::WIN0_LOC) || (a == sfrc_pkg::WIN1_LOC);
  endfunction : is_window

  // Data memory read for a given bank; windows and unused locations give zero
  function automatic logic [7:0] mem_read(input logic bank, input logic [7:0] a);
    if (is_window(a)) begin
      mem_read = sfrc_pkg::ZERO_BYTE;
    end else if (a < sfrc_pkg::GP_BASE) begin
      mem_read = sfrc_pkg::ZERO_BYTE;
    end else if (bank) begin
      mem_read = mem1[a];
    end else begin
      mem_read = mem0[a];
    end
  endfunction : mem_read

  // Arithmetic on the result register with operand from pwdata
  always_comb begin
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] b;
    s = 9'h000;
    n = 5'h00;
    b = wbyte;
    alu = '0;
    case (sfrc_pkg::sfrc_op_t'(pwdata[11:8]))
      sfrc_pkg::SFRC_OP_ADD: begin
        s = {1'b0, result_holding_register} + {1'b0, b};
        n = {1'b0, result_holding_register[3:0]} + {1'b0, b[3:0]};
        alu.value = s[7:0];
        alu.carry = s[8];
        alu.half = n[4];
        alu.range = (result_holding_register[7] == b[7]) && (s[7] != b[7]);
      end
      sfrc_pkg::SFRC_OP_SUB: begin
        s = {1'b0, result_holding_register} + {1'b0, ~b} + 9'h001;
        n = {1'b0, result_holding_register[3:0]} + {1'b0, ~b[3:0]} + 5'h01;
        alu.value = s[7:0];
        alu.carry = s[8];
        alu.half = n[4];
        alu.range = (result_holding_register[7] != b[7]) && (s[7] != result_holding_register[7]);
      end
      sfrc_pkg::SFRC_OP_AND: alu.value = result_holding_register & b;
      sfrc_pkg::SFRC_OP_OR: alu.value = result_holding_register | b;
      sfrc_pkg::SFRC_OP_XOR: alu.value = result_holding_register ^ b;
      sfrc_pkg::SFRC_OP_RLC: begin
        alu.value = {result_holding_register[6:0], status_flags_register[sfrc_pkg::ST_CARRY]};
        alu.carry = result_holding_register[7];
      end
      sfrc_pkg::SFRC_OP_RRC: begin
        alu.value = {status_flags_register[sfrc_pkg::ST_CARRY], result_holding_register[7:1]};
        alu.carry = result_holding_register[0];
      end
      default: alu.value = result_holding_register;
    endcase
  end

  wire logic [3:0] op = pwdata[11:8];
  wire logic cmd_wr = wr_en && (paddr == sfrc_pkg::ADDR_CMD);
  wire logic is_arith = (op == sfrc_pkg::SFRC_OP_ADD) || (op == sfrc_pkg::SFRC_OP_SUB);
  wire logic is_logic = (op == sfrc_pkg::SFRC_OP_AND) || (op == sfrc_pkg::SFRC_OP_OR) ||
                        (op == sfrc_pkg::SFRC_OP_XOR);
  wire logic is_rot = (op == sfrc_pkg::SFRC_OP_RLC) || (op == sfrc_pkg::SFRC_OP_RRC);

  // Bank select; a watchdog reset while sleeping must keep it, so that reset is synchronous
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bank_select_register <= sfrc_pkg::BANK_RESET;
    end else if (watchdog_reset && !sleeping) begin
      bank_select_register <= sfrc_pkg::BANK_RESET;
    end else if (watchdog_reset) begin
      bank_select_register <= bank_select_register;
    end else if (wr_en && paddr == sfrc_pkg::ADDR_BANK) begin
      bank_select_register <= {7'b000_0000, wbyte[sfrc_pkg::BANK_BIT]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleeping <= 1'b0;
    end else if (watchdog_reset || (cmd_wr && op == sfrc_pkg::SFRC_OP_WDOG_CLEAR)) begin
      sleeping <= 1'b0;
    end else if (cmd_wr && op == sfrc_pkg::SFRC_OP_HALT) begin
      sleeping <= 1'b1;
    end
  end

  // Status register; every flag, arithmetic ones included, clears to zero at power-on
  // No save path to any stack: software must keep it across calls itself
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_flags_register <= sfrc_pkg::ZERO_BYTE;
    end else begin
      if (wr_en && paddr == sfrc_pkg::ADDR_STATUS) begin
        status_flags_register[3:0] <= wbyte[3:0] & sfrc_pkg::MASK_STATUS_WR[3:0];
      end
      if (cmd_wr) begin
        if (is_arith) begin
          status_flags_register[sfrc_pkg::ST_CARRY] <= alu.carry;
          status_flags_register[sfrc_pkg::ST_HALF] <= alu.half;
          status_flags_register[sfrc_pkg::ST_RANGE] <= alu.range;
          status_flags_register[sfrc_pkg::ST_NULL] <= (alu.value == sfrc_pkg::ZERO_BYTE);
        end else if (is_logic) begin
          status_flags_register[sfrc_pkg::ST_NULL] <= (alu.value == sfrc_pkg::ZERO_BYTE);
        end else if (is_rot) begin
          status_flags_register[sfrc_pkg::ST_CARRY] <= alu.carry;
        end
        if (op == sfrc_pkg::SFRC_OP_WDOG_CLEAR) begin
          status_flags_register[sfrc_pkg::ST_WDOG] <= 1'b0;
          status_flags_register[sfrc_pkg::ST_SLEEP] <= 1'b0;
        end else if (op == sfrc_pkg::SFRC_OP_HALT) begin
          status_flags_register[sfrc_pkg::ST_WDOG] <= 1'b0;
          status_flags_register[sfrc_pkg::ST_SLEEP] <= 1'b1;
        end
      end
      if (watchdog_reset) begin
        status_flags_register[sfrc_pkg::ST_WDOG] <= 1'b1;
      end
      status_flags_register[7:6] <= 2'b00;
    end
  end

  // Result register; the only path between two memory locations
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_holding_register <= sfrc_pkg::ZERO_BYTE;
    end else if (wr_en && paddr == sfrc_pkg::ADDR_RESULT) begin
      result_holding_register <= wbyte;
    end else if (cmd_wr && op == sfrc_pkg::SFRC_OP_MOVA) begin
      result_holding_register <= mem_read(1'b0, wbyte);
    end else if (cmd_wr && (is_arith || is_logic || is_rot)) begin
      result_holding_register <= alu.value;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      memory_pointer_0 <= sfrc_pkg::ZERO_BYTE;
      memory_pointer_1 <= sfrc_pkg::ZERO_BYTE;
      table_pointer <= sfrc_pkg::ZERO_BYTE;
    end else if (wr_en) begin
      if (paddr == sfrc_pkg::ADDR_PTR0) begin
        memory_pointer_0 <= wbyte;
      end else if (paddr == sfrc_pkg::ADDR_PTR1) begin
        memory_pointer_1 <= wbyte;
      end else if (paddr == sfrc_pkg::ADDR_TBLP) begin
        table_pointer <= wbyte;
      end
    end
  end

  // Memory writes: window 0 to bank 0, window 1 to selected bank, direct to bank 0
  always_ff @(posedge pclk) begin
    if (wr_en && paddr == sfrc_pkg::ADDR_WIN0 && !is_window(memory_pointer_0) &&
        memory_pointer_0 >= sfrc_pkg::GP_BASE) begin
      mem0[memory_pointer_0] <= wbyte;
    end
    if (wr_en && paddr == sfrc_pkg::ADDR_WIN1 && !is_window(memory_pointer_1) &&
        memory_pointer_1 >= sfrc_pkg::GP_BASE) begin
      if (bank_select_register[sfrc_pkg::BANK_BIT]) begin
        mem1[memory_pointer_1] <= wbyte;
      end else begin
        mem0[memory_pointer_1] <= wbyte;
      end
    end
    if (wr_en && paddr == sfrc_pkg::ADDR_DIRECT && pwdata[15:8] >= sfrc_pkg::GP_BASE) begin
      mem0[pwdata[15:8]] <= wbyte;
    end
    if (tab_pend && tab_dest >= sfrc_pkg::GP_BASE) begin
      mem0[tab_dest] <= prog_word[7:0];
    end
  end

  // Program counter; low byte write jumps within the page and costs a dummy cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pc_q <= 11'h000;
      dummy_cycle <= 1'b0;
    end else begin
      dummy_cycle <= 1'b0;
      if (wr_en && paddr == sfrc_pkg::ADDR_PC_LOW) begin
        pc_q <= {pc_q[10:8], wbyte};
        dummy_cycle <= 1'b1;
      end else if (wr_en && paddr == sfrc_pkg::ADDR_PCH) begin
        pc_q <= {pwdata[2:0], pc_q[7:0]};
      end
    end
  end

  // Table read: address on the next cycle, word captured the cycle after
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tab_pend <= 1'b0;
      tab_dest <= sfrc_pkg::ZERO_BYTE;
      table_high_byte <= sfrc_pkg::ZERO_BYTE;
      prog_addr <= 11'h000;
    end else begin
      tab_pend <= 1'b0;
      if (cmd_wr && op == sfrc_pkg::SFRC_OP_TABRD) begin
        prog_addr <= {pc_q[10:8], table_pointer};
        tab_dest <= wbyte;
        tab_pend <= 1'b1;
      end
      if (tab_pend) begin
        table_high_byte <= prog_word[15:8];
      end
    end
  end

  always_comb begin
    next_rd = sfrc_pkg::ZERO_BYTE;
    if (paddr == sfrc_pkg::ADDR_BANK) begin
      next_rd = bank_select_register;
    end else if (paddr == sfrc_pkg::ADDR_STATUS) begin
      next_rd = status_flags_register;
    end else if (paddr == sfrc_pkg::ADDR_PTR0) begin
      next_rd = memory_pointer_0;
    end else if (paddr == sfrc_pkg::ADDR_PTR1) begin
      next_rd = memory_pointer_1;
    end else if (paddr == sfrc_pkg::ADDR_PC_LOW) begin
      next_rd = pc_q[7:0];
    end else if (paddr == sfrc_pkg::ADDR_TBLP) begin
      next_rd = table_pointer;
    end else if (paddr == sfrc_pkg::ADDR_TABLE_HIGH) begin
      next_rd = table_high_byte;
    end else if (paddr == sfrc_pkg::ADDR_RESULT) begin
      next_rd = result_holding_register;
    end else if (paddr == sfrc_pkg::ADDR_WIN0) begin
      next_rd = mem_read(1'b0, memory_pointer_0);
    end else if (paddr == sfrc_pkg::ADDR_WIN1) begin
      next_rd = mem_read(bank_select_register[sfrc_pkg::BANK_BIT], memory_pointer_1);
    end else if (paddr == sfrc_pkg::ADDR_DIRECT) begin
      next_rd = mem_read(1'b0, pwdata[15:8]);
    end else if (paddr == sfrc_pkg::ADDR_PCH) begin
      next_rd = {5'b0_0000, pc_q[10:8]};
    end
  end

  // Zero-wait APB; unmapped addresses read zero without error
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite) begin
        prdata <= {24'h00_0000, next_rd};
      end
    end
  end

  assign pc = pc_q;
endmodule : sfrc_core
`default_nettype wire

// ==== testbench/sfrc_checker.sv ====
// Port-level assertions for the special function register core
`timescale 1ns/1ps
`default_nettype none
module sfrc_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [10:0] pc,
  input wire logic dummy_cycle
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic rd_ok;
  logic pc_low_wr;
  assign rd_ok = pready && psel && penable && !pwrite;
  assign pc_low_wr = pready && psel && penable && pwrite && paddr == sfrc_pkg::ADDR_PC_LOW;
  property p_ready_setup;
    psel && !penable |=> pready;
  endproperty
  a_ready_setup: assert property (p_ready_setup) else $error("no answer in access cycle");
  property p_ready_pulse;
    pready |=> !pready;
  endproperty
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready held too long");
  property p_ready_access;
    pready |-> psel && penable;
  endproperty
  a_ready_access: assert property (p_ready_access) else $error("ready outside access");
  property p_no_error;
    pslverr == 1'b0;
  endproperty
  a_no_error: assert property (p_no_error) else $error("error response raised");
  property p_bank_bits;
    rd_ok && paddr == sfrc_pkg::ADDR_BANK |-> prdata[7:1] == 7'h00;
  endproperty
  a_bank_bits: assert property (p_bank_bits) else $error("bank upper bits set");
  property p_status_bits;
    rd_ok && paddr == sfrc_pkg::ADDR_STATUS |-> prdata[7:6] == 2'h0;
  endproperty
  a_status_bits: assert property (p_status_bits) else $error("status top bits set");
  property p_unused_zero;
    rd_ok && paddr == 32'h0000_0FFC |-> prdata[7:0] == 8'h00;
  endproperty
  a_unused_zero: assert property (p_unused_zero) else $error("unused place not zero");
  property p_dummy;
    pc_low_wr |-> ##[1:2] dummy_cycle;
  endproperty
  a_dummy: assert property (p_dummy) else $error("no dummy cycle");
  property p_dummy_single;
    dummy_cycle |=> !dummy_cycle;
  endproperty
  a_dummy_single: assert property (p_dummy_single) else $error("dummy cycle too long");
  property p_page_kept;
    pc_low_wr |=> pc[7:0] == $past(pwdata[7:0]) && pc[10:8] == $past(pc[10:8]);
  endproperty
  a_page_kept: assert property (p_page_kept) else $error("jump left the page");
  property p_reset_quiet;
    $rose(presetn) |-> prdata == 32'h0000_0000 && !pready;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("outputs busy after reset");
  c_pc_low_write: cover property (pc_low_wr);
  c_bank_read: cover property (rd_ok && paddr == sfrc_pkg::ADDR_BANK);
  c_status_read: cover property (rd_ok && paddr == sfrc_pkg::ADDR_STATUS);
endmodule : sfrc_checker
`default_nettype wire

// ==== testbench/test_sfrc_core.sv ====
// Self-checking bench for the special function register core
`timescale 1ns/1ps
`default_nettype none
module test_sfrc_core;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, watchdog_reset, dummy_cycle;
  logic [31:0] paddr, pwdata, prdata, rd_data;
  logic [15:0] prog_word;
  logic [10:0] prog_addr, pc;
  int failures = 0;
  int checks_done = 0;
  int cycles = 0;
  // Start, opcode, operand, result, flags {range, null, half, carry}
  logic [31:0] alu_tab [8] = '{32'h7F10_180A, 32'hF030_F00E, 32'h0140_001A, 32'h5555_500E,
                               32'h0520_5007, 32'h0810_8102, 32'h8060_0003, 32'h0270_0812};
  // Program memory echoes its address so table reads are predictable
  assign prog_word = {5'h14, prog_addr};
  sfrc_core i_sfrc_core (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .watchdog_reset(watchdog_reset), .prog_word(prog_word), .prog_addr(prog_addr),
    .pc(pc), .dummy_cycle(dummy_cycle));
  task automatic wrap_up();
    if (failures == 0 && checks_done > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : wrap_up
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check
  // An idle cycle follows each transfer so no strobe is driven twice in one step
  task automatic xfer(input logic wr, input logic [31:0] addr, input logic [31:0] data);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= data;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_data = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : xfer
  task automatic rdc(input logic [31:0] addr, input logic [31:0] data, input logic [7:0] exp);
    xfer(1'b0, addr, data);
    check({24'h00_0000, rd_data[7:0]}, {24'h00_0000, exp});
  endtask : rdc
  task automatic cmd(input logic [3:0] op, input logic [7:0] arg);
    xfer(1'b1, sfrc_pkg::ADDR_CMD, {20'h0_0000, op, arg});
  endtask : cmd
  task automatic pulse_watchdog();
    watchdog_reset <= 1'b1;
    @(posedge pclk);
    watchdog_reset <= 1'b0;
    @(posedge pclk);
  endtask : pulse_watchdog
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      failures++;
      wrap_up();
    end
  end
  initial begin
    {psel, penable, pwrite, watchdog_reset, presetn} = 5'h00;
    paddr = 32'h0000_0000;
    pwdata = 32'h0000_0000;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(sfrc_pkg::ADDR_BANK, 32'h0000_0000, 8'h00);
    xfer(1'b0, sfrc_pkg::ADDR_STATUS, 32'h0000_0000);
    check({28'h000_0000, rd_data[7:4]}, 32'h0000_0000);
    xfer(1'b1, sfrc_pkg::ADDR_BANK, 32'h0000_00FF);
    rdc(sfrc_pkg::ADDR_BANK, 32'h0000_0000, 8'h01);
    xfer(1'b1, sfrc_pkg::ADDR_PTR1, 32'h0000_0090);
    xfer(1'b1, sfrc_pkg::ADDR_WIN1, 32'h0000_00A5);
    xfer(1'b1, sfrc_pkg::ADDR_DIRECT, 32'h0000_903C);
    rdc(sfrc_pkg::ADDR_DIRECT, 32'h0000_9000, 8'h3C);
    rdc(sfrc_pkg::ADDR_WIN1, 32'h0000_0000, 8'hA5);
    xfer(1'b1, sfrc_pkg::ADDR_PTR0, 32'h0000_0090);
    rdc(sfrc_pkg::ADDR_WIN0, 32'h0000_0000, 8'h3C);
    xfer(1'b1, sfrc_pkg::ADDR_BANK, 32'h0000_0000);
    rdc(sfrc_pkg::ADDR_WIN1, 32'h0000_0000, 8'h3C);
    xfer(1'b1, sfrc_pkg::ADDR_PTR1, {24'h00_0000, sfrc_pkg::WIN0_LOC});
    xfer(1'b1, sfrc_pkg::ADDR_WIN1, 32'h0000_0077);
    rdc(sfrc_pkg::ADDR_WIN1, 32'h0000_0000, 8'h00);
    rdc(sfrc_pkg::ADDR_WIN0, 32'h0000_0000, 8'h3C);
    rdc(32'h0000_0FFC, 32'h0000_0000, 8'h00);
    rdc(sfrc_pkg::ADDR_DIRECT, 32'h0000_4000, 8'h00);
    cmd(sfrc_pkg::SFRC_OP_MOVA, 8'h90);
    rdc(sfrc_pkg::ADDR_RESULT, 32'h0000_0000, 8'h3C);
    xfer(1'b1, sfrc_pkg::ADDR_PCH, 32'h0000_0007);
    xfer(1'b1, sfrc_pkg::ADDR_TBLP, 32'h0000_0006);
    cmd(sfrc_pkg::SFRC_OP_TABRD, 8'h91);
    @(posedge pclk);
    rdc(sfrc_pkg::ADDR_TABLE_HIGH, 32'h0000_0000, 8'hA7);
    rdc(sfrc_pkg::ADDR_DIRECT, 32'h0000_9100, 8'h06);
    xfer(1'b1, sfrc_pkg::ADDR_PC_LOW, 32'h0000_0034);
    check({21'h0_0000, pc}, 32'h0000_0734);
    xfer(1'b1, sfrc_pkg::ADDR_STATUS, 32'h0000_00FF);
    rdc(sfrc_pkg::ADDR_STATUS, 32'h0000_0000, 8'h0F);
    xfer(1'b1, sfrc_pkg::ADDR_BANK, 32'h0000_0001);
    cmd(sfrc_pkg::SFRC_OP_HALT, 8'h00);
    rdc(sfrc_pkg::ADDR_STATUS, 32'h0000_0000, 8'h1F);
    pulse_watchdog();
    rdc(sfrc_pkg::ADDR_STATUS, 32'h0000_0000, 8'h3F);
    rdc(sfrc_pkg::ADDR_BANK, 32'h0000_0000, 8'h01);
    xfer(1'b1, sfrc_pkg::ADDR_STATUS, 32'h0000_0000);
    rdc(sfrc_pkg::ADDR_STATUS, 32'h0000_0000, 8'h30);
    cmd(sfrc_pkg::SFRC_OP_HALT, 8'h00);
    rdc(sfrc_pkg::ADDR_STATUS, 32'h0000_0000, 8'h10);
    cmd(sfrc_pkg::SFRC_OP_WDOG_CLEAR, 8'h00);
    rdc(sfrc_pkg::ADDR_STATUS, 32'h0000_0000, 8'h00);
    pulse_watchdog();
    rdc(sfrc_pkg::ADDR_BANK, 32'h0000_0000, 8'h00);
    cmd(sfrc_pkg::SFRC_OP_WDTO, 8'h00);
    rdc(sfrc_pkg::ADDR_STATUS, 32'h0000_0000, 8'h20);
    foreach (alu_tab[i]) begin
      xfer(1'b1, sfrc_pkg::ADDR_RESULT, {24'h00_0000, alu_tab[i][31:24]});
      cmd(alu_tab[i][23:20], alu_tab[i][19:12]);
      rdc(sfrc_pkg::ADDR_RESULT, 32'h0000_0000, alu_tab[i][11:4]);
      xfer(1'b0, sfrc_pkg::ADDR_STATUS, 32'h0000_0000);
      check({28'h000_0000, rd_data[3:0]}, {28'h000_0000, alu_tab[i][3:0]});
    end
    wrap_up();
  end
endmodule : test_sfrc_core
bind sfrc_core sfrc_checker i_sfrc_checker (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .pc(pc), .dummy_cycle(dummy_cycle));
`default_nettype wire
